// ==== design/dma_channel_event_irq_control.sv ====
// One DMA channel's start/abort event control and sticky interrupt flags.
// Assumes a classic Wishbone master and a datapath that reports progress.
//
// Contract
// - Abort-interrupt selector aborts and sets abort flag
// - Start-interrupt selector picks the starting interrupt
// - Force bit starts transfer, reads zero
// - Software abort bit aborts, reads zero
// - Pattern abort clears channel enable when enabled
// - Start enable gates selected start interrupt
// - Abort enable gates selected abort interrupt
// - Selectors reset ones, controls zero, gaps zero
// - Destination done when pointer equals size
// - Destination half when pointer equals half size
// - Block done on larger size or match
// - Cell done after each cell size
// - Transfer abort flag on abort interrupt
// - Address error flag on invalid address
`timescale 1ns/10ps
`default_nettype none
module dma_channel_event_irq_control #(
  parameter int NUM_IRQ = 256,
  parameter int PTR_W   = 16
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Classic Wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [3:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic [31:0]             dat_o,
  output logic                    ack_o,
  output logic                    err_o,
  // Interrupt sources
  input  wire logic [NUM_IRQ-1:0] irq_lines_i,
  // Transfer datapath
  input  wire logic               pattern_match_i,
  input  wire logic               byte_xfer_i,
  input  wire logic [PTR_W-1:0]   dest_pointer_i,
  input  wire logic [PTR_W-1:0]   dest_size_i,
  input  wire logic [PTR_W-1:0]   source_size_i,
  input  wire logic [PTR_W-1:0]   cell_size_i,
  input  wire logic               addr_error_i,
  input  wire logic               channel_enable_set_i,
  output logic                    channel_enable_o,
  output logic                    start_cell_o,
  output logic                    abort_o,
  output logic                    irq_o
);

  logic [7:0]  abort_irq_select_q;
  logic [7:0]  start_irq_select_q;
  logic        pattern_abort_enable_q;
  logic        start_irq_enable_q;
  logic        abort_irq_enable_q;
  logic [5:0]  flags_q;
  logic [5:0]  mask_q;
  logic        channel_enable_q;
  logic        ack_q;
  logic        err_q;
  logic [31:0] dat_q;
  logic        start_q;
  logic        abort_q;
  logic [PTR_W-1:0] cell_count_q;
  logic [PTR_W-1:0] block_count_q;
  logic [PTR_W-1:0] dest_ptr_prev_q;

  logic start_hit;
  logic abort_hit;
  logic req;
  logic wr;
  logic mapped;
  logic force_transfer;
  logic software_abort;
  logic pattern_abort;
  logic [5:0] flag_set;
  logic [5:0] flag_clr;
  logic [PTR_W-1:0] block_size;
  logic [PTR_W-1:0] cell_next;
  logic [PTR_W-1:0] block_next;
  logic cell_end;
  logic block_end;

  irq_number_match #(
    .NUM_IRQ (NUM_IRQ),
    .SEL_W   (dma_event_pkg::SEL_W)
  ) u_start_match (
    .irq_lines_i (irq_lines_i),
    .select_i    (start_irq_select_q),
    .enable_i    (start_irq_enable_q),
    .hit_o       (start_hit)
  );

  irq_number_match #(
    .NUM_IRQ (NUM_IRQ),
    .SEL_W   (dma_event_pkg::SEL_W)
  ) u_abort_match (
    .irq_lines_i (irq_lines_i),
    .select_i    (abort_irq_select_q),
    .enable_i    (abort_irq_enable_q),
    .hit_o       (abort_hit)
  );

  // Bus decode; one access answered per request, ack drops next cycle
  assign req    = cyc_i && stb_i && !ack_q && !err_q;
  assign mapped = (adr_i == dma_event_pkg::ECON_ADDR) ||
                  (adr_i == dma_event_pkg::FLAGS_ADDR) ||
                  (adr_i == dma_event_pkg::MASK_ADDR) ||
                  (adr_i == dma_event_pkg::STATUS_ADDR);
  assign wr     = req && we_i && mapped;

  // Self-clearing command bits live only as write strobes
  assign force_transfer = wr && (adr_i == dma_event_pkg::ECON_ADDR) &&
                          sel_i[0] && dat_i[dma_event_pkg::FORCE_BIT];
  assign software_abort = wr && (adr_i == dma_event_pkg::ECON_ADDR) &&
                          sel_i[0] &&
                          dat_i[dma_event_pkg::SWABORT_BIT];
  assign pattern_abort  = pattern_abort_enable_q && pattern_match_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      abort_irq_select_q     <= dma_event_pkg::SEL_RESET;
      start_irq_select_q     <= dma_event_pkg::SEL_RESET;
      pattern_abort_enable_q <= 1'b0;
      start_irq_enable_q     <= 1'b0;
      abort_irq_enable_q     <= 1'b0;
    end else if (wr && adr_i == dma_event_pkg::ECON_ADDR) begin
      if (sel_i[2]) begin
        abort_irq_select_q <= dat_i[23:16];
      end
      if (sel_i[1]) begin
        start_irq_select_q <= dat_i[15:8];
      end
      if (sel_i[0]) begin
        pattern_abort_enable_q <= dat_i[dma_event_pkg::PAT_EN_BIT];
        start_irq_enable_q     <= dat_i[dma_event_pkg::START_EN_BIT];
        abort_irq_enable_q     <= dat_i[dma_event_pkg::ABORT_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= dma_event_pkg::MASK_RESET;
    end else if (wr && adr_i == dma_event_pkg::MASK_ADDR && sel_i[0]) begin
      mask_q <= dat_i[5:0];
    end
  end

  // Channel enable: datapath sets it, any abort clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_enable_q <= 1'b0;
    end else if (pattern_abort || abort_hit || software_abort) begin
      channel_enable_q <= 1'b0;
    end else if (channel_enable_set_i) begin
      channel_enable_q <= 1'b1;
    end
  end

  // Start and abort pulses to the datapath; abort takes priority
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      abort_q <= abort_hit || software_abort || pattern_abort;
      start_q <= (start_hit || force_transfer) &&
                 !(abort_hit || software_abort || pattern_abort);
    end
  end

  // Progress counters for cell and block boundaries
  assign block_size = (source_size_i > dest_size_i) ?
                      source_size_i : dest_size_i;
  assign cell_next  = cell_count_q + 1'b1;
  assign block_next = block_count_q + 1'b1;
  assign cell_end   = byte_xfer_i && (cell_next == cell_size_i);
  assign block_end  = byte_xfer_i && (block_next == block_size);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_count_q  <= '0;
      block_count_q <= '0;
    end else if (abort_q || start_q && !channel_enable_q) begin
      cell_count_q  <= '0;
      block_count_q <= '0;
    end else if (byte_xfer_i) begin
      cell_count_q  <= cell_end ? '0 : cell_next;
      block_count_q <= block_end ? '0 : block_next;
    end
  end

  // Pointer compares fire once, on arrival at the mark
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dest_ptr_prev_q <= '0;
    end else begin
      dest_ptr_prev_q <= dest_pointer_i;
    end
  end

  always_comb begin
    flag_set = '0;
    flag_set[dma_event_pkg::DEST_DONE_BIT] =
      (dest_pointer_i == dest_size_i) &&
      (dest_ptr_prev_q != dest_pointer_i);
    flag_set[dma_event_pkg::DEST_HALF_BIT] =
      (dest_pointer_i == (dest_size_i >> 1)) &&
      (dest_ptr_prev_q != dest_pointer_i);
    flag_set[dma_event_pkg::BLOCK_DONE_BIT] =
      block_end || pattern_match_i;
    flag_set[dma_event_pkg::CELL_DONE_BIT]  = cell_end;
    flag_set[dma_event_pkg::XFER_ABORT_BIT] = abort_hit;
    flag_set[dma_event_pkg::ADDR_ERR_BIT]   = addr_error_i;
  end

  assign flag_clr = (wr && adr_i == dma_event_pkg::FLAGS_ADDR && sel_i[0]) ?
                    dat_i[5:0] : 6'h00;

  // Write-one-to-clear; a set in the same cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < dma_event_pkg::NUM_FLAGS; gi++) begin : g_flag
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flags_q[gi] <= dma_event_pkg::FLAGS_RESET[gi];
        end else if (flag_set[gi]) begin
          flags_q[gi] <= 1'b1;
        end else if (flag_clr[gi]) begin
          flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Read data and answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req && mapped;
      err_q <= req && !mapped;
      dat_q <= 32'h0000_0000;
      if (req && !we_i) begin
        unique case (adr_i)
          dma_event_pkg::ECON_ADDR: begin
            // Command bits and gaps read zero
            dat_q <= {8'h00, abort_irq_select_q, start_irq_select_q,
                      2'b00, pattern_abort_enable_q, start_irq_enable_q,
                      abort_irq_enable_q, 3'b000};
          end
          dma_event_pkg::FLAGS_ADDR: begin
            dat_q <= {26'h0, flags_q};
          end
          dma_event_pkg::MASK_ADDR: begin
            dat_q <= {26'h0, mask_q};
          end
          dma_event_pkg::STATUS_ADDR: begin
            dat_q <= {30'h0, channel_enable_q, irq_o};
          end
          default: begin
            dat_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign dat_o            = dat_q;
  assign ack_o            = ack_q;
  assign err_o            = err_q;
  assign channel_enable_o = channel_enable_q;
  assign start_cell_o     = start_q;
  assign abort_o          = abort_q;
  assign irq_o            = |(flags_q & mask_q);

endmodule
`default_nettype wire

// ==== design/dma_event_pkg.sv ====
// Constants for the channel event and flag logic.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package dma_event_pkg;

  // Register byte addresses
  localparam logic [3:0] ECON_ADDR   = 4'h0;
  localparam logic [3:0] FLAGS_ADDR  = 4'h4;
  localparam logic [3:0] MASK_ADDR   = 4'h8;
  localparam logic [3:0] STATUS_ADDR = 4'hC;

  // Event control fields
  localparam int ABORT_SEL_LSB   = 16;
  localparam int START_SEL_LSB   = 8;
  localparam int FORCE_BIT       = 7;
  localparam int SWABORT_BIT     = 6;
  localparam int PAT_EN_BIT      = 5;
  localparam int START_EN_BIT    = 4;
  localparam int ABORT_EN_BIT    = 3;
  localparam int SEL_W           = 8;

  localparam logic [7:0] SEL_RESET = 8'hFF;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Flag bit positions
  localparam int DEST_DONE_BIT  = 5;
  localparam int DEST_HALF_BIT  = 4;
  localparam int BLOCK_DONE_BIT = 3;
  localparam int CELL_DONE_BIT  = 2;
  localparam int XFER_ABORT_BIT = 1;
  localparam int ADDR_ERR_BIT   = 0;
  localparam int NUM_FLAGS      = 6;

  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [5:0] MASK_RESET  = 6'h00;

endpackage

// ==== design/irq_number_match.sv ====
// Detects an occurrence of one selected interrupt number out of 256 lines.
// Assumes the source lines are single-cycle pulses in the clock domain.
`timescale 1ns/10ps
`default_nettype none
module irq_number_match #(
  parameter int NUM_IRQ = 256,
  parameter int SEL_W   = 8
) (
  input  wire logic [NUM_IRQ-1:0] irq_lines_i,
  input  wire logic [SEL_W-1:0]   select_i,
  input  wire logic               enable_i,
  output logic                    hit_o
);

  // Index reaching past NUM_IRQ reads as no event
  always_comb begin
    hit_o = 1'b0;
    if (enable_i && (32'(select_i) < NUM_IRQ)) begin
      hit_o = irq_lines_i[select_i];
    end
  end

endmodule
`default_nettype wire

// ==== verif/dma_channel_event_irq_control_tb_top.sv ====
// Bench for the channel event block, Wishbone master and far side.
// Assumes sizes dest 8, source 10, cell 4 held fixed.
`timescale 1ns/10ps
`default_nettype none
module dma_channel_event_irq_control_tb_top;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc_i = 1'b0;
  logic         stb_i = 1'b0;
  logic         we_i  = 1'b0;
  logic [3:0]   adr_i = 4'h0;
  logic [31:0]  dat_i = 32'h0;
  logic [3:0]   sel_i = 4'hF;
  logic [3:0]   ws    = 4'hF;
  // Source larger than destination, so block end tests the larger size
  logic [15:0]  dsz   = 16'h0008;
  logic [15:0]  ssz   = 16'h000A;
  logic [15:0]  csz   = 16'h0004;
  logic [31:0]  dat_o, q;
  logic         ack_o, err_o, e, en_o, st_o, ab_o, irq_o, bx;
  logic [255:0] irq;
  logic [2:0]   ev;
  logic [15:0]  dp;
  logic [7:0]   s, a;
  int           fails, checks, n_st, n_ab, b;
  always #2.5 clk_i = ~clk_i;
  dma_channel_event_irq_control dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .irq_lines_i(irq),
    .pattern_match_i(ev[0]), .byte_xfer_i(bx), .dest_pointer_i(dp),
    .dest_size_i(dsz), .source_size_i(ssz),
    .cell_size_i(csz), .addr_error_i(ev[1]),
    .channel_enable_set_i(ev[2]), .channel_enable_o(en_o),
    .start_cell_o(st_o), .abort_o(ab_o), .irq_o);
  dma_far_side_model pm (.clk_i, .irq_lines_o(irq), .ev_o(ev),
    .byte_xfer_o(bx), .dest_pointer_o(dp));
  always @(posedge clk_i) begin
    n_st += int'(st_o === 1'b1);
    n_ab += int'(ab_o === 1'b1);
  end
  function automatic logic [31:0] econ(input logic [7:0] c);
    return {8'h00, a, s, c & 8'h38};
  endfunction
  task automatic chk(input string n, input logic [31:0] x, g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, ad, ws, d};
    // The wait ends on ack_o or err_o; only if neither comes does the watchdog end it
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o;
    e = err_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic rchk(input string n, input logic [3:0] ad, logic [31:0] x);
    wb(1'b0, ad, 32'h0);
    chk(n, x, q);
  endtask
  // Pulses are counted one edge late, so let them land first
  task automatic cnt(input string n, input int xs, xa);
    repeat (2) @(posedge clk_i);
    chk(n, xs, n_st);
    chk(n, xa, n_ab);
    n_st = 0;
    n_ab = 0;
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    conclude();
  end
  initial begin
    void'($urandom(62068));
    s = 8'($urandom);
    a = s ^ 8'h5A;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("econ", dma_event_pkg::ECON_ADDR, 32'h00FFFF00);
    wb(1'b0, 4'h2, 32'h0);
    chk("err", 32'h1, 32'(e));
    wb(1'b1, dma_event_pkg::ECON_ADDR, {8'h00, a, s, 8'hFF});
    rchk("econ", dma_event_pkg::ECON_ADDR, econ(8'hFF));
    cnt("force_abort", 0, 1);
    pm.fire(s);
    cnt("start_irq", 1, 0);
    wb(1'b1, dma_event_pkg::FLAGS_ADDR, 32'h3F);
    pm.fire(a);
    cnt("abort_irq", 0, 1);
    rchk("flags", dma_event_pkg::FLAGS_ADDR, 32'h2);
    wb(1'b1, dma_event_pkg::ECON_ADDR, {8'h00, a, s, 8'h00});
    pm.fire(s);
    pm.fire(a);
    cnt("gated", 0, 0);
    ws = 4'h1;
    wb(1'b1, dma_event_pkg::ECON_ADDR, {8'h00, ~a, ~s, 8'h18});
    ws = 4'hF;
    rchk("econ_lane", dma_event_pkg::ECON_ADDR, econ(8'h18));
    wb(1'b1, dma_event_pkg::ECON_ADDR, {8'h00, a, s, 8'h80});
    cnt("force", 1, 0);
    wb(1'b1, dma_event_pkg::FLAGS_ADDR, 32'h3F);
    wb(1'b1, dma_event_pkg::ECON_ADDR, {8'h00, a, s, 8'h40});
    cnt("sw_abort", 0, 1);
    for (b = 0; b < 2; b++) begin
      wb(1'b1, dma_event_pkg::ECON_ADDR, {8'h00, a, s, b ? 8'h20 : 8'h00});
      pm.pulse(2);
      pm.pulse(0);
      cnt("pattern", 0, b);
      chk("enable", 32'(1 - b), 32'(en_o));
    end
    rchk("flags", dma_event_pkg::FLAGS_ADDR, 32'h8);
    wb(1'b1, dma_event_pkg::MASK_ADDR, 32'h3F);
    pm.pulse(1);
    rchk("flags", dma_event_pkg::FLAGS_ADDR, 32'h9);
    chk("irq", 32'h1, 32'(irq_o));
    rchk("status", dma_event_pkg::STATUS_ADDR, 32'h1);
    wb(1'b1, dma_event_pkg::MASK_ADDR, 32'h0);
    chk("irq_masked", 32'h0, 32'(irq_o));
    wb(1'b1, dma_event_pkg::MASK_ADDR, 32'h3F);
    wb(1'b1, dma_event_pkg::FLAGS_ADDR, 32'h3F);
    chk("irq_clear", 32'h0, 32'(irq_o));
    pm.xfer(4);
    rchk("flags", dma_event_pkg::FLAGS_ADDR, 32'h14);
    pm.xfer(4);
    rchk("flags", dma_event_pkg::FLAGS_ADDR, 32'h34);
    pm.xfer(2);
    rchk("flags", dma_event_pkg::FLAGS_ADDR, 32'h3C);
    chk("irq", 32'h1, 32'(irq_o));
    conclude();
  end
endmodule
bind dma_channel_event_irq_control dma_event_chk #(.NUM_IRQ(NUM_IRQ)) u_chk (.*);
`default_nettype wire

// ==== verif/dma_event_chk.sv ====
// Checker for the channel event block: bus answers and event pulses.
// Assumes a bind onto the channel top; watches its ports only.
`timescale 1ns/10ps
`default_nettype none
module dma_event_chk #(
  parameter int NUM_IRQ = 256
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               cyc_i,
  input wire logic               stb_i,
  input wire logic               we_i,
  input wire logic [3:0]         adr_i,
  input wire logic [31:0]        dat_o,
  input wire logic               ack_o,
  input wire logic               err_o,
  input wire logic [NUM_IRQ-1:0] irq_lines_i,
  input wire logic               pattern_match_i,
  input wire logic               channel_enable_o,
  input wire logic               start_cell_o,
  input wire logic               abort_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic mapped;
  logic wr;
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign mapped = adr_i[1:0] == 2'h0;
  assign wr = req && we_i;
  a_mapped_ack: assert property (req && mapped |=> ack_o && !err_o)
    else $error("mapped access not acked");
  a_unmapped_err: assert property (req && !mapped |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_idle_quiet: assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o)
    else $error("answer without request");
  a_econ_gaps: assert property (ack_o && $past(!we_i && adr_i == 4'h0)
    |-> (dat_o & 32'hFF0000C7) == 32'h0)
    else $error("event control gap bits not zero");
  a_abort_wins: assert property (abort_o |-> !start_cell_o)
    else $error("start beside abort");
  a_start_cause: assert property (start_cell_o |-> $past(wr)
    || $past(|irq_lines_i))
    else $error("start without cause");
  a_abort_cause: assert property (abort_o |-> $past(wr)
    || $past(|irq_lines_i) || $past(pattern_match_i))
    else $error("abort without cause");
  a_enable_drop: assert property ($fell(channel_enable_o)
    |-> abort_o || $past(abort_o))
    else $error("enable cleared without abort");
  c_start: cover property (start_cell_o);
  c_abort: cover property (abort_o);
  c_err: cover property (err_o);
endmodule
`default_nettype wire

// ==== verif/dma_far_side_model.sv ====
// Interrupt sources and transfer datapath beside the channel.
// Assumes the bench calls its tasks from one sequence.
`timescale 1ns/10ps
`default_nettype none
module dma_far_side_model (
  input  wire logic   clk_i,
  output logic [255:0] irq_lines_o,
  output logic [2:0]   ev_o,
  output logic         byte_xfer_o,
  output logic [15:0]  dest_pointer_o
);
  initial begin
    irq_lines_o = '0;
    ev_o = 3'h0;
    byte_xfer_o = 1'b0;
    dest_pointer_o = 16'h0000;
  end
  task automatic fire(input int n);
    @(posedge clk_i) irq_lines_o[n] <= 1'b1;
    @(posedge clk_i) irq_lines_o[n] <= 1'b0;
  endtask
  // Bit 0 pattern match, 1 address error, 2 enable set
  task automatic pulse(input int k);
    @(posedge clk_i) ev_o[k] <= 1'b1;
    @(posedge clk_i) ev_o[k] <= 1'b0;
  endtask
  // Pointer moves with each byte so the match sees a change
  task automatic xfer(input int k);
    repeat (k) begin
      @(posedge clk_i);
      byte_xfer_o <= 1'b1;
      dest_pointer_o <= dest_pointer_o + 16'h0001;
    end
    @(posedge clk_i) byte_xfer_o <= 1'b0;
  endtask
endmodule
`default_nettype wire
